// ==== flh_apb_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flh_cfg.svh"
module flh_apb_regs (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic busy_in,
	input wire logic done_in,
	input wire logic fail_in,
	input wire logic toggled_in,
	input wire logic [3:0] tries_in,
	input wire logic [15:0] result_in,
	output logic go_out,
	output flh_pkg::flh_op_type op_out,
	output logic [3:0] lim_out,
	output logic [22:0] addr_out,
	output logic [15:0] data_out,
	output logic [63:0] pw_out
);
	import flh_pkg::*;
	flh_regs_reg_type r, n;
	logic wr_acc;
	// APB slave: answer prepared in setup, one access cycle, unmapped gives pslverr
	always_comb begin
		n = r;
		n.go = 1'b0;
		n.pready = psel_in & ~penable_in;
		n.pslverr = 1'b0;
		wr_acc = psel_in & penable_in & r.pready & pwrite_in & ~r.pslverr;
		if (psel_in && !penable_in) begin
			n.prdata = 32'h0000_0000;
			case (paddr_in)
				`FLH_REG_CTRL: n.prdata = {16'h0000, r.lim, 7'h00, r.op};
				`FLH_REG_ADDR: n.prdata = {9'h000, r.addr};
				`FLH_REG_DATA: n.prdata = {16'h0000, r.data};
				`FLH_REG_PW_LO: n.prdata = r.pw[31:0];
				`FLH_REG_PW_HI: n.prdata = r.pw[63:32];
				`FLH_REG_STATUS: n.prdata = {20'h00000, tries_in, 4'h0, toggled_in, fail_in, r.done, busy_in};
				`FLH_REG_RESULT: n.prdata = {16'h0000, result_in};
				default: n.pslverr = 1'b1;
			endcase
		end
		if (wr_acc) begin
			case (paddr_in)
				`FLH_REG_CTRL: if (!busy_in) begin
					n.op = flh_op_type'(pwdata_in[4:0]);
					n.lim = pwdata_in[`FLH_CTRL_LIM_LSB +: 4];
					n.go = pwdata_in[`FLH_CTRL_GO];
				end
				`FLH_REG_ADDR: if (!busy_in) n.addr = pwdata_in[22:0];
				`FLH_REG_DATA: if (!busy_in) n.data = pwdata_in[15:0];
				`FLH_REG_PW_LO: if (!busy_in) n.pw[31:0] = pwdata_in;
				`FLH_REG_PW_HI: if (!busy_in) n.pw[63:32] = pwdata_in;
				`FLH_REG_STATUS: if (pwdata_in[`FLH_ST_DONE]) n.done = 1'b0;
				default: n.go = 1'b0;
			endcase
		end
		// Completion set wins over a clear in the same cycle
		if (done_in) n.done = 1'b1;
	end
	// State register
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) r <= '{op: OP_RESET, lim: `FLH_LIM_RESET, default: '0};
		else r <= n;
	end
	assign prdata_out = r.prdata;
	assign pready_out = r.pready;
	assign pslverr_out = r.pslverr;
	assign go_out = r.go;
	assign op_out = r.op;
	assign lim_out = r.lim;
	assign addr_out = r.addr;
	assign data_out = r.data;
	assign pw_out = r.pw;
endmodule
`default_nettype wire

// ==== flh_bus_cycle.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flh_cfg.svh"
module flh_bus_cycle #(
	parameter int WR_STB_CYC = 4,
	parameter int RD_STB_CYC = 12,
	parameter int HOLD_CYC = 2
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic start_in,
	input wire logic wr_in,
	input wire logic [22:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic [15:0] dq_in,
	output logic done_out,
	output logic [15:0] rdata_out,
	output logic [22:0] addr_out,
	output logic [15:0] dq_out,
	output logic dq_oe_out,
	output logic we_n_out,
	output logic oe_n_out,
	output logic ce_n_out
);
	import flh_pkg::*;
	flh_bus_reg_type r, n;
	// One write or read cycle: setup, strobe low, strobe high with hold
	always_comb begin
		n = r;
		n.done = 1'b0;
		unique case (r.st)
			BUS_IDLE: if (start_in) begin
				n.addr = addr_in;
				n.dq = wdata_in;
				n.wr = wr_in;
				n.dq_oe = wr_in;
				n.ce_n = 1'b0;
				n.st = BUS_SETUP;
			end
			BUS_SETUP: begin
				n.we_n = ~r.wr;
				n.oe_n = r.wr;
				n.cnt = r.wr ? 8'(WR_STB_CYC - 1) : 8'(RD_STB_CYC - 1);
				n.st = BUS_STROBE;
			end
			BUS_STROBE: if (r.cnt == 8'h00) begin
				n.we_n = 1'b1; // Device latches data on this rising edge
				n.oe_n = 1'b1;
				if (!r.wr) n.rdata = dq_in;
				n.cnt = 8'(HOLD_CYC - 1);
				n.st = BUS_HOLD;
			end else begin
				n.cnt = r.cnt - 8'h01;
			end
			BUS_HOLD: if (r.cnt == 8'h00) begin
				n.ce_n = 1'b1;
				n.dq_oe = 1'b0;
				n.done = 1'b1;
				n.st = BUS_IDLE;
			end else begin
				n.cnt = r.cnt - 8'h01;
			end
			default: n.st = BUS_IDLE;
		endcase
	end
	// State register, pins idle high
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) r <= '{st: BUS_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
		else r <= n;
	end
	assign done_out = r.done;
	assign rdata_out = r.rdata;
	assign addr_out = r.addr;
	assign dq_out = r.dq;
	assign dq_oe_out = r.dq_oe;
	assign we_n_out = r.we_n;
	assign oe_n_out = r.oe_n;
	assign ce_n_out = r.ce_n;
endmodule
`default_nettype wire

// ==== flh_cfg.svh ====
`ifndef FLH_CFG_SVH
`define FLH_CFG_SVH
// ****************************************
// Timing
// ****************************************
`define FLH_CLK_PERIOD_NS 10
`define FLH_T_LOCK_PROG_US 100
`define FLH_T_ALL_ERASE_MS 1.2
`define FLH_T_PW_GAP_US 2
`define FLH_WAIT_W 17
// ****************************************
// Register map and fields
// ****************************************
`define FLH_REG_CTRL 8'h00
`define FLH_REG_ADDR 8'h04
`define FLH_REG_DATA 8'h08
`define FLH_REG_PW_LO 8'h0c
`define FLH_REG_PW_HI 8'h10
`define FLH_REG_STATUS 8'h14
`define FLH_REG_RESULT 8'h18
`define FLH_CTRL_GO 8
`define FLH_CTRL_LIM_LSB 12
`define FLH_ST_BUSY 0
`define FLH_ST_DONE 1
`define FLH_ST_FAIL 2
`define FLH_ST_TOGGLED 3
`define FLH_ST_TRIES_LSB 8
`define FLH_LIM_RESET 4'h3
// ****************************************
// Flash bus codes
// ****************************************
`define FLH_A_UNLOCK1 23'h000555
`define FLH_A_UNLOCK2 23'h0002aa
`define FLH_D_UNLOCK1 16'h00aa
`define FLH_D_UNLOCK2 16'h0055
`define FLH_LA_SECURE 8'h1a
`define FLH_LA_PPB 8'h02
`define FLH_LA_PWMODE 8'h0a
`define FLH_LA_PSMODE 8'h12
`define FLH_C_RESET 16'h00f0
`define FLH_C_AUTOSEL 16'h0090
`define FLH_C_PROT 16'h0060
`define FLH_C_LOCK_PGM 16'h0068
`define FLH_C_LOCK_VFY 16'h0048
`define FLH_C_ALL_ERASE 16'h0040
`define FLH_C_LOCK_SET 16'h0078
`define FLH_C_STAT 16'h0058
`define FLH_C_DYB 16'h0048
`define FLH_C_PW_PGM 16'h0038
`define FLH_C_PW_VFY 16'h00c8
`define FLH_C_PW_UNLOCK 16'h0028
`define FLH_C_WORD_PGM 16'h00a0
`define FLH_C_ERASE 16'h0080
`define FLH_C_SECT_ERASE 16'h0030
`define FLH_DQ_POLL 7
`define FLH_DQ_TOGGLE 6
`define FLH_DQ_LIMIT 5
`endif

// ==== flh_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module flh_flash_model (
	input wire logic ce_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	input wire logic [22:0] addr_in,
	input wire logic [15:0] dq_in,
	input wire logic stuck_in,
	input wire logic guard_in,
	input wire logic [3:0] busy_len_in,
	output logic [15:0] dq_out,
	output logic ready_busy_out,
	output logic [22:0] lock_addr_out,
	output logic [22:0] last_addr_out
);
	logic [15:0] last_r = 16'h0, word_r = 16'h0, pdat_r = 16'h0, val_r = 16'h0;
	logic [3:0] busy_r = 4'h0;
	logic erase_r = 1'b0, prot_r = 1'b0, tog_r = 1'b0, guard_r = 1'b0;
	// Reads act as the output strobe falls, commands decode as the write strobe rises
	always @(posedge we_n_in or negedge oe_n_in) begin
		if (!oe_n_in) begin
			if (busy_r != 4'h0) begin
				busy_r <= stuck_in ? busy_r : busy_r - 4'h1;
				tog_r <= ~tog_r;
				val_r <= {8'h00, ~erase_r & ~pdat_r[7], ~tog_r, stuck_in, 5'h00};
			end else if (last_r == 16'h00c8)
				val_r <= 16'hffff;
			else
				val_r <= (last_r == 16'h0048 || last_r == 16'h0040) ? {15'h0, prot_r} : word_r;
		end else begin
			if (last_r == 16'h00a0) begin
				// A guarded target keeps its old word and leaves the pin released
				{pdat_r, erase_r, busy_r, guard_r} <= {dq_in, 1'b0, busy_len_in, guard_in};
				if (!guard_in)
					word_r <= dq_in;
			end else if (dq_in == 16'h0030)
				{word_r, erase_r, busy_r, guard_r} <= {16'hffff, 1'b1, busy_len_in, 1'b0};
			else if (dq_in == 16'h0068 || dq_in == 16'h0040) begin
				prot_r <= dq_in[5];
				if (dq_in[5])
					lock_addr_out <= addr_in;
			end else if (dq_in == 16'h00f0)
				busy_r <= 4'h0;
			last_r <= dq_in;
			last_addr_out <= addr_in;
		end
	end
	// Pulled-up busy pin; a released bus shows the inverse
	assign ready_busy_out = busy_r == 4'h0 || guard_r;
	assign dq_out = (!oe_n_in && !ce_n_in) ? val_r : ~val_r;
endmodule
`default_nettype wire

// ==== flh_host_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flh_cfg.svh"
module flh_host_ctrl #(
	parameter int T_LOCK_PROG_CYC = int'($ceil(`FLH_T_LOCK_PROG_US * 1000.0 / `FLH_CLK_PERIOD_NS)),
	parameter int T_ALL_ERASE_CYC = int'($ceil(`FLH_T_ALL_ERASE_MS * 1000000.0 / `FLH_CLK_PERIOD_NS)),
	parameter int WR_STB_CYC = 4,
	parameter int RD_STB_CYC = 12,
	parameter int HOLD_CYC = 2
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic [22:0] flash_addr_out,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe_out,
	input wire logic [15:0] flash_dq_in,
	output logic flash_we_n_out,
	output logic flash_oe_n_out,
	output logic flash_chip_enable_n_out,
	input wire logic ready_busy_pin_in
);
	import flh_pkg::*;

	// ****************************************
	// Timing counts
	// ****************************************
	localparam int T_PW_GAP_CYC = int'($ceil(`FLH_T_PW_GAP_US * 1000.0 / `FLH_CLK_PERIOD_NS));

	flh_ctrl_reg_type r, n;
	flh_step_type cur;
	flh_op_type reg_op;
	logic reg_go, bus_done;
	logic [3:0] reg_lim;
	logic [22:0] reg_addr;
	logic [15:0] reg_data, bus_rdata;
	logic [63:0] reg_pw;
	logic exp_dq7;

	// ****************************************
	// Software registers
	// ****************************************
	flh_apb_regs u_regs (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.psel_in(psel_in),
		.penable_in(penable_in),
		.pwrite_in(pwrite_in),
		.paddr_in(paddr_in),
		.pwdata_in(pwdata_in),
		.prdata_out(prdata_out),
		.pready_out(pready_out),
		.pslverr_out(pslverr_out),
		.busy_in(r.busy),
		.done_in(r.done),
		.fail_in(r.fail),
		.toggled_in(r.toggled),
		.tries_in(r.tries),
		.result_in(r.result),
		.go_out(reg_go),
		.op_out(reg_op),
		.lim_out(reg_lim),
		.addr_out(reg_addr),
		.data_out(reg_data),
		.pw_out(reg_pw)
	);

	// ****************************************
	// Flash bus cycles
	// ****************************************
	flh_bus_cycle #(
		.WR_STB_CYC(WR_STB_CYC),
		.RD_STB_CYC(RD_STB_CYC),
		.HOLD_CYC(HOLD_CYC)
	) u_bus (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.start_in(r.go),
		.wr_in(r.bus_wr),
		.addr_in(r.bus_addr),
		.wdata_in(r.bus_data),
		.dq_in(flash_dq_in),
		.done_out(bus_done),
		.rdata_out(bus_rdata),
		.addr_out(flash_addr_out),
		.dq_out(flash_dq_out),
		.dq_oe_out(flash_dq_oe_out),
		.we_n_out(flash_we_n_out),
		.oe_n_out(flash_oe_n_out),
		.ce_n_out(flash_chip_enable_n_out)
	);

	// ****************************************
	// Command sequence table
	// ****************************************
	// Builds one step record
	function automatic flh_step_type mk(flh_step_kind_type k, logic [22:0] a, logic [15:0] d);
		flh_step_type s;
		s.kind = k;
		s.addr = a;
		s.data = d;
		return s;
	endfunction

	// Autoselect entry then reset, used to leave lock programming cleanly
	function automatic flh_step_type tail(logic [4:0] k);
		flh_step_type s;
		case (k)
			5'd0: s = mk(STP_WR, `FLH_A_UNLOCK1, `FLH_D_UNLOCK1);
			5'd1: s = mk(STP_WR, `FLH_A_UNLOCK2, `FLH_D_UNLOCK2);
			5'd2: s = mk(STP_WR, `FLH_A_UNLOCK1, `FLH_C_AUTOSEL);
			5'd3: s = mk(STP_WR, 23'h000000, `FLH_C_RESET);
			default: s = mk(STP_END, 23'h000000, 16'h0000);
		endcase
		return s;
	endfunction

	// Step idx of operation op; steps 0 to 2 are the unlock and command cycles, except OP_RESET, whose step 0 is the reset write
	function automatic flh_step_type step_of(flh_op_type op, logic [4:0] idx, logic [22:0] a,
		logic [15:0] d, logic [63:0] pw);
		flh_step_type s;
		logic [22:0] la;
		logic [15:0] cmd;
		logic [1:0] p;
		s = mk(STP_END, 23'h000000, 16'h0000);
		la = {a[22:8], `FLH_LA_PPB};
		cmd = `FLH_C_PROT;
		p = a[1:0];
		case (op)
			OP_SEC_PROG, OP_SEC_STAT: la = {15'h0000, `FLH_LA_SECURE};
			OP_PWM_PROG, OP_PWM_STAT: la = {15'h0000, `FLH_LA_PWMODE};
			OP_PSM_PROG, OP_PSM_STAT: la = {15'h0000, `FLH_LA_PSMODE};
			OP_LOCK_SET: cmd = `FLH_C_LOCK_SET;
			OP_LOCK_STAT, OP_DYB_STAT: cmd = `FLH_C_STAT;
			OP_DYB_SET, OP_DYB_CLR: cmd = `FLH_C_DYB;
			OP_PW_PROG: cmd = `FLH_C_PW_PGM;
			OP_PW_VERIFY: cmd = `FLH_C_PW_VFY;
			OP_PW_UNLOCK: cmd = `FLH_C_PW_UNLOCK;
			OP_WORD_PROG: cmd = `FLH_C_WORD_PGM;
			OP_SECT_ERASE: cmd = `FLH_C_ERASE;
			OP_AUTOSEL_EXIT: cmd = `FLH_C_AUTOSEL;
			default: cmd = `FLH_C_PROT;
		endcase
		if (op == OP_RESET) begin
			if (idx == 5'd0) s = mk(STP_WR, 23'h000000, `FLH_C_RESET);
		end else if (idx == 5'd0) begin
			s = mk(STP_WR, `FLH_A_UNLOCK1, `FLH_D_UNLOCK1);
		end else if (idx == 5'd1) begin
			s = mk(STP_WR, `FLH_A_UNLOCK2, `FLH_D_UNLOCK2);
		end else if (idx == 5'd2) begin
			s = mk(STP_WR, `FLH_A_UNLOCK1, cmd);
		end else begin
			case (op)
				OP_SEC_PROG, OP_PPB_PROG, OP_PWM_PROG, OP_PSM_PROG: case (idx)
					5'd3: s = mk(STP_WR, la, `FLH_C_LOCK_PGM);
					5'd4: s = mk(STP_WAIT_PROG, la, 16'h0000);
					5'd5: s = mk(STP_WR, la, `FLH_C_LOCK_VFY);
					5'd6: s = mk(STP_RD_V1, la, 16'h0000);
					default: s = tail(5'(idx - 5'd7));
				endcase
				OP_SEC_STAT, OP_PPB_STAT, OP_PWM_STAT, OP_PSM_STAT: case (idx)
					5'd3: s = mk(STP_WR, la, `FLH_C_LOCK_VFY);
					5'd4: s = mk(STP_RD_DQ0, la, 16'h0000);
					default: s = mk(STP_END, la, 16'h0000);
				endcase
				OP_PPB_ERASE_ALL: case (idx)
					5'd3: s = mk(STP_WR, la, `FLH_C_PROT);
					5'd4: s = mk(STP_WAIT_ERASE, la, 16'h0000);
					5'd5: s = mk(STP_WR, la, `FLH_C_ALL_ERASE);
					5'd6: s = mk(STP_RD_V0, la, 16'h0000);
					default: s = mk(STP_END, la, 16'h0000);
				endcase
				OP_LOCK_SET: s = tail(5'(idx - 5'd3));
				OP_LOCK_STAT: if (idx == 5'd3) s = mk(STP_RD_DQ1, a, 16'h0000);
				OP_DYB_SET: if (idx == 5'd3) s = mk(STP_WR, a, 16'h0001);
				OP_DYB_CLR: if (idx == 5'd3) s = mk(STP_WR, a, 16'h0000);
				OP_DYB_STAT: if (idx == 5'd3) s = mk(STP_RD_DQ0, a, 16'h0000);
				OP_PW_PROG: case (idx)
					5'd3: s = mk(STP_WR, {21'h000000, p}, pw[16 * p +: 16]);
					5'd4: s = mk(STP_WAIT_PW, a, 16'h0000);
					default: s = mk(STP_END, a, 16'h0000);
				endcase
				// A locked password mode returns ffff here; it is reported as read
				OP_PW_VERIFY: if (idx == 5'd3) s = mk(STP_RD_WORD, {21'h000000, p}, 16'h0000);
				OP_PW_UNLOCK: if (idx < 5'd7) begin
					p = 2'(idx - 5'd3);
					s = mk(STP_WR, {21'h000000, p}, pw[16 * p +: 16]);
				end
				OP_WORD_PROG: case (idx)
					5'd3: s = mk(STP_WR, a, d);
					5'd4: s = mk(STP_POLL, a, 16'h0000);
					default: s = mk(STP_END, a, 16'h0000);
				endcase
				OP_SECT_ERASE: case (idx)
					5'd3: s = mk(STP_WR, `FLH_A_UNLOCK1, `FLH_D_UNLOCK1);
					5'd4: s = mk(STP_WR, `FLH_A_UNLOCK2, `FLH_D_UNLOCK2);
					5'd5: s = mk(STP_WR, a, `FLH_C_SECT_ERASE);
					5'd6: s = mk(STP_POLL, a, 16'h0000);
					default: s = mk(STP_END, a, 16'h0000);
				endcase
				OP_AUTOSEL_EXIT: if (idx == 5'd3) s = mk(STP_WR, 23'h000000, `FLH_C_RESET);
				default: s = mk(STP_END, a, 16'h0000);
			endcase
		end
		return s;
	endfunction

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		n = r;
		n.go = 1'b0;
		n.done = 1'b0;
		cur = step_of(r.op, r.idx, r.addr, r.data, r.pw);
		// Program expects true data bit 7, erase expects 1
		exp_dq7 = (r.op == OP_WORD_PROG) ? r.data[`FLH_DQ_POLL] : 1'b1;
		unique case (r.st)
			ST_IDLE: if (reg_go) begin
				n.op = reg_op;
				n.lim = reg_lim;
				n.addr = reg_addr;
				n.data = reg_data;
				n.pw = reg_pw;
				n.idx = 5'd0;
				n.tries = 4'h0;
				n.busy = 1'b1;
				n.fail = 1'b0;
				n.toggled = 1'b0;
				n.st = ST_FETCH;
			end
			ST_FETCH: begin
				n.bus_addr = cur.addr;
				n.bus_data = cur.data;
				n.prev_valid = 1'b0;
				n.recheck = 1'b0;
				n.final_rd = 1'b0;
				unique case (cur.kind)
					STP_WR, STP_RD_V1, STP_RD_V0, STP_RD_DQ0, STP_RD_DQ1, STP_RD_WORD: begin
						n.go = 1'b1;
						n.bus_wr = (cur.kind == STP_WR);
						n.st = ST_BUS;
					end
					STP_WAIT_PROG: begin
						n.cnt = `FLH_WAIT_W'(T_LOCK_PROG_CYC - 1);
						n.st = ST_WAIT;
					end
					STP_WAIT_ERASE: begin
						n.cnt = `FLH_WAIT_W'(T_ALL_ERASE_CYC - 1);
						n.st = ST_WAIT;
					end
					STP_WAIT_PW: begin
						n.cnt = `FLH_WAIT_W'(T_PW_GAP_CYC - 1);
						n.st = ST_WAIT;
					end
					STP_POLL: begin
						// First read follows the last write strobe's release
						n.go = 1'b1;
						n.bus_wr = 1'b0;
						n.st = ST_POLL;
					end
					STP_END: begin
						n.busy = 1'b0;
						n.done = 1'b1;
						n.st = ST_IDLE;
					end
				endcase
			end
			ST_BUS: if (bus_done) begin
				n.idx = r.idx + 5'd1;
				n.st = ST_FETCH;
				case (cur.kind)
					STP_RD_V1, STP_RD_V0: begin
						if (bus_rdata[0] != (cur.kind == STP_RD_V1)) begin
							// Verify failed: reissue the whole sequence while tries remain
							if (r.tries < r.lim) begin
								n.tries = r.tries + 4'h1;
								n.idx = 5'd0;
							end else begin
								n.fail = 1'b1;
								n.busy = 1'b0;
								n.done = 1'b1;
								n.st = ST_IDLE;
							end
						end
					end
					STP_RD_DQ0: n.result = {15'h0000, bus_rdata[0]};
					STP_RD_DQ1: n.result = {15'h0000, bus_rdata[1]};
					STP_RD_WORD: n.result = bus_rdata;
					default: n.result = r.result;
				endcase
			end
			ST_WAIT: if (r.cnt == `FLH_WAIT_W'(0)) begin
				n.idx = r.idx + 5'd1;
				n.st = ST_FETCH;
			end else begin
				n.cnt = r.cnt - `FLH_WAIT_W'(1);
			end
			ST_POLL: if (bus_done) begin
				n.go = 1'b1;
				n.prev_valid = 1'b1;
				n.prev_dq6 = bus_rdata[`FLH_DQ_TOGGLE];
				if (r.prev_valid && (r.prev_dq6 != bus_rdata[`FLH_DQ_TOGGLE])) n.toggled = 1'b1;
				if (r.final_rd) begin
					// Word read is the next read after the one where bit 7 went true
					n.go = 1'b0;
					n.result = bus_rdata;
					n.idx = r.idx + 5'd1;
					n.st = ST_FETCH;
				end else if (bus_rdata[`FLH_DQ_POLL] == exp_dq7) begin
					n.final_rd = 1'b1;
				end else if (r.recheck) begin
					// Still busy after the limit flag: reset back to array reads
					n.bus_wr = 1'b1;
					n.bus_addr = 23'h000000;
					n.bus_data = `FLH_C_RESET;
					n.fail = 1'b1;
					n.st = ST_ABORT;
				end else if (bus_rdata[`FLH_DQ_LIMIT]) begin
					n.recheck = 1'b1;
				end else if (ready_busy_pin_in && r.prev_valid && (r.prev_dq6 == bus_rdata[`FLH_DQ_TOGGLE])) begin
					// Pin released and bit 6 steady: target was protected, bank reads array again
					n.go = 1'b0;
					n.fail = 1'b1;
					n.busy = 1'b0;
					n.done = 1'b1;
					n.st = ST_IDLE;
				end
			end
			ST_ABORT: if (bus_done) begin
				n.busy = 1'b0;
				n.done = 1'b1;
				n.st = ST_IDLE;
			end
			default: n.st = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) r <= '{st: ST_IDLE, op: OP_RESET, default: '0};
		else r <= n;
	end
endmodule
`default_nettype wire

// ==== flh_host_ctrl_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module flh_host_ctrl_bench;
	logic clk_in = 1'b0, arst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, stuck = 1'b0, guard = 1'b0, err;
	logic [7:0] pa = 8'h00;
	logic [31:0] password_portion_data = 32'h0, rd;
	logic [3:0] blen = 4'h0;
	logic [15:0] seed = 16'hf9d5;
	int errors = 0, n_checks = 0;
	wire logic [31:0] prd;
	wire logic rdy, serr, we_n, oe_n, ce_n, dq_oe, rb;
	wire logic [15:0] dqo, dqm, dq;
	wire logic [22:0] fa, la, wa;
	// Bus level from whichever side drives it
	assign dq = dq_oe ? dqo : dqm;
	flh_host_ctrl #(.T_LOCK_PROG_CYC(20), .T_ALL_ERASE_CYC(40)) i_dut (.clk_in(clk_in), .arst_n_in(arst_n),
		.psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(password_portion_data), .prdata_out(prd),
		.pready_out(rdy), .pslverr_out(serr), .flash_addr_out(fa), .flash_dq_out(dqo), .flash_dq_oe_out(dq_oe),
		.flash_dq_in(dq), .flash_we_n_out(we_n), .flash_oe_n_out(oe_n), .flash_chip_enable_n_out(ce_n),
		.ready_busy_pin_in(rb));
	flh_flash_model i_flash (.ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(fa), .dq_in(dq),
		.stuck_in(stuck), .guard_in(guard), .busy_len_in(blen), .dq_out(dqm), .ready_busy_out(rb),
		.lock_addr_out(la), .last_addr_out(wa));
	// Free-running clock
	initial forever #5 clk_in = ~clk_in;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Low address byte of the lock bit that a lock-program op targets
	function automatic logic [7:0] lock_low(input int op);
		return (op == 1) ? 8'h1a : (op == 11) ? 8'h0a : (op == 13) ? 8'h12 : 8'h02;
	endfunction
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (!ok) begin
			errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// One transfer, held until the ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_in);
		{psel, pen, pwr, pa, password_portion_data} <= {2'b10, w, a, d};
		@(posedge clk_in);
		pen <= 1'b1;
		do begin
			@(posedge clk_in);
			k++;
		end while (rdy !== 1'b1 && k < 20);
		{rd, err} = {prd, serr};
		{psel, pen} <= 2'b00;
		if (k >= 20) begin
			errors++;
			summarize();
		end
	endtask
	// Start an operation, poll until done, fetch its result
	task automatic run(input logic [4:0] op, input logic exp_fail);
		int k;
		k = 0;
		apb(1'b1, 8'h14, 32'h2);
		apb(1'b1, 8'h00, {16'h0, 4'h3, 3'h0, 1'b1, 3'h0, op});
		do begin
			apb(1'b0, 8'h14, 32'h0);
			k++;
		end while (rd[1] !== 1'b1 && k < 3000);
		check(rd[2] === exp_fail && k < 3000, "completion");
		if (k >= 3000)
			summarize();
		apb(1'b0, 8'h18, 32'h0);
		$display("test op %0d ends", op);
	endtask
	// Reset, registers, random programs, every command, stuck device
	initial begin
		repeat (3) @(posedge clk_in);
		arst_n <= 1'b1;
		apb(1'b0, 8'h14, 32'h0);
		check(rd === 32'h0, "reset status");
		apb(1'b0, 8'h1c, 32'h0);
		check(err === 1'b1 && rd === 32'h0, "unmapped");
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			blen <= (i < 2) ? 4'(i) : seed[11:8];
			apb(1'b1, 8'h04, {9'h0, seed[6:0], seed});
			apb(1'b1, 8'h08, {16'h0, seed});
			run(5'd18, 1'b0);
			check(rd[15:0] === seed, "word");
		end
		run(5'd19, 1'b0);
		check(rd[15:0] === 16'hffff, "erase");
		for (int i = 0; i < 21; i++) begin
			if (i != 18 && i != 19)
				run(5'(i), 1'b0);
			if (i == 1 || i == 3 || i == 11 || i == 13)
				check(la[7:0] === lock_low(i), "lock address");
			if (i == 4)
				check(rd[0] === 1'b1, "lock bit");
			if (i == 16)
				check(rd[15:0] === 16'hffff, "password hidden");
			if (i == 17)
				check(wa === 23'h000003, "password portion");
		end
		{stuck, blen} <= 5'h13;
		run(5'd18, 1'b1);
		stuck <= 1'b0;
		{guard, blen} <= 5'h12;
		apb(1'b1, 8'h08, {16'h0, ~seed});
		run(5'd18, 1'b1);
		guard <= 1'b0;
		summarize();
	end
endmodule
`default_nettype wire

// ==== flh_host_ctrl_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module flh_host_ctrl_monitor (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [22:0] flash_addr_out,
	input wire logic flash_dq_oe_out,
	input wire logic flash_we_n_out,
	input wire logic flash_oe_n_out,
	input wire logic flash_chip_enable_n_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	// Bus answer and strobe relations
	a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out) else $error("late ready");
	a_ready_one_cycle: assert property (pready_out |=> !pready_out) else $error("long ready");
	a_err_with_ready: assert property (pslverr_out |-> pready_out) else $error("lone error");
	a_strobes_apart: assert property (flash_we_n_out || flash_oe_n_out) else $error("both strobes");
	a_write_drives_bus: assert property (!flash_we_n_out |-> flash_dq_oe_out && !flash_chip_enable_n_out)
		else $error("bad write");
	a_read_floats_bus: assert property (!flash_oe_n_out |-> !flash_dq_oe_out && !flash_chip_enable_n_out)
		else $error("bad read");
	a_enable_first: assert property ($fell(flash_we_n_out) || $fell(flash_oe_n_out) |-> !$past(flash_chip_enable_n_out))
		else $error("strobe before enable");
	a_addr_held_read: assert property (!flash_oe_n_out && !$past(flash_oe_n_out) |-> $stable(flash_addr_out))
		else $error("address moved");
endmodule
bind flh_host_ctrl flh_host_ctrl_monitor i_mon (.clk_in, .arst_n_in, .psel_in, .penable_in, .pready_out, .pslverr_out,
	.flash_addr_out, .flash_dq_oe_out, .flash_we_n_out, .flash_oe_n_out, .flash_chip_enable_n_out);
`default_nettype wire

// ==== flh_pkg.sv ====
`include "flh_cfg.svh"
package flh_pkg;
	typedef enum logic [4:0] {OP_RESET, OP_SEC_PROG, OP_SEC_STAT, OP_PPB_PROG, OP_PPB_STAT, OP_PPB_ERASE_ALL,
		OP_LOCK_SET, OP_LOCK_STAT, OP_DYB_SET, OP_DYB_CLR, OP_DYB_STAT, OP_PWM_PROG, OP_PWM_STAT,
		OP_PSM_PROG, OP_PSM_STAT, OP_PW_PROG, OP_PW_VERIFY, OP_PW_UNLOCK, OP_WORD_PROG, OP_SECT_ERASE,
		OP_AUTOSEL_EXIT} flh_op_type;
	typedef enum logic [3:0] {STP_WR, STP_RD_V1, STP_RD_V0, STP_RD_DQ0, STP_RD_DQ1, STP_RD_WORD,
		STP_WAIT_PROG, STP_WAIT_ERASE, STP_WAIT_PW, STP_POLL, STP_END} flh_step_kind_type;
	typedef struct packed {
		flh_step_kind_type kind;
		logic [22:0] addr;
		logic [15:0] data;
	} flh_step_type;
	typedef enum logic [3:0] {BUS_IDLE = 4'h1, BUS_SETUP = 4'h2, BUS_STROBE = 4'h4, BUS_HOLD = 4'h8} flh_bus_state_type;
	typedef struct packed {
		flh_bus_state_type st;
		logic [7:0] cnt;
		logic wr, done, dq_oe, ce_n, we_n, oe_n;
		logic [22:0] addr;
		logic [15:0] dq, rdata;
	} flh_bus_reg_type;
	typedef enum logic [5:0] {ST_IDLE = 6'h01, ST_FETCH = 6'h02, ST_BUS = 6'h04, ST_WAIT = 6'h08,
		ST_POLL = 6'h10, ST_ABORT = 6'h20} flh_state_type;
	typedef struct packed {
		flh_state_type st;
		flh_op_type op;
		logic [4:0] idx;
		logic [3:0] tries, lim;
		logic [22:0] addr;
		logic [15:0] data;
		logic [63:0] pw;
		logic [`FLH_WAIT_W-1:0] cnt;
		logic go, bus_wr, busy, done, fail, toggled;
		logic prev_valid, prev_dq6, recheck, final_rd;
		logic [22:0] bus_addr;
		logic [15:0] bus_data, result;
	} flh_ctrl_reg_type;
	typedef struct packed {
		flh_op_type op;
		logic [3:0] lim;
		logic [22:0] addr;
		logic [15:0] data;
		logic [63:0] pw;
		logic go, done, pready, pslverr;
		logic [31:0] prdata;
	} flh_regs_reg_type;
endpackage
